/* File: inc/sbi_regs.svh */
// register map, field positions, codes and timing counts of the serial bus block
`ifndef SBI_REGS_SVH
`define SBI_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CTRL_A   8'h20
`define OFS_DATA     8'h21
`define OFS_TADDR    8'h22
`define OFS_CTRL_B   8'h23
`define OFS_CLK_SRC  8'h24
`define OFS_PORT_SW  8'h27

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CRA_BC       7:5
`define CRA_ACK      4
`define CRA_SCK      2:0
`define SRA_MON      0
`define TA_ADDR      7:1
`define TA_ALS       0
`define CRB_MST      7
`define CRB_TRX      6
`define CRB_BB       5
`define CRB_PIN      4
`define CRB_MODE     3:2
`define CRB_SOFT_RESET_CODE    1:0
`define PSW_CHS      6
`define CLK_SRC_RUN  0

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define MODE_SIO     2'h1
`define MODE_I2C     2'h2
`define SOFT_RESET_CODE_FIRST  2'h1
`define SOFT_RESET_CODE_SECOND 2'h2
`define BC_FULL      3'h0
`define BITS_FULL    4'h8
`define GENERAL_CALL 8'h00
`define RST_PIN      1'h1
`define RST_CLK_RUN  1'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SRST_MCYCLES    4
`define CLKS_PER_MCYCLE 4
`define SRST_CLKS       5'(`SRST_MCYCLES * `CLKS_PER_MCYCLE)
`define SCL_HALF_BASE   11'h010
`define SCL_HALF_EXTRA  11'h004
`define SCK_MAX         3'h6

`endif

/* File: inc/sbi_pkg.sv */
// types shared by the serial bus block
package sbi_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_START_A  = 3'h1,
    ST_START_B  = 3'h3,
    ST_BIT_LOW  = 3'h2,
    ST_BIT_HIGH = 3'h6,
    ST_WAIT     = 3'h7,
    ST_STOP_A   = 3'h5,
    ST_STOP_B   = 3'h4
  } bus_state_t;

  typedef struct packed {
    bus_state_t st;
    logic [2:0] bit_count;
    logic       ack_mode;
    logic [2:0] sck;
    logic [7:0] shreg;
    logic [6:0] own_target_addr;
    logic       addr_recognition_off;
    logic       controller_role;
    logic       transmit_direction;
    logic       bus_busy;
    logic       pending;
    logic [1:0] operating_mode_sel;
    logic [1:0] soft_reset_code;
    logic       arbitration_lost;
    logic       address_match_flag;
    logic       general_call_flag;
    logic       last_received_bit;
    logic       channel_select;
    logic       clk_run;
    logic [3:0] cnt;
    logic       first;
    logic       stop_req;
    logic       smp;
    logic       scl_p;
    logic       sda_p;
    logic       scl_drv;
    logic       sda_drv;
    logic [4:0] srst_cnt;
    logic [3:0] oe;
    logic [7:0] rdata;
  } core_state_t;

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
  } sync_state_t;

  typedef struct packed {
    logic [10:0] cnt;
    logic        tick;
  } div_state_t;

endpackage

/* File: inc/sbi_clk_if.sv */
// serial clock divider control and tick bundle
`timescale 1ns/10ps
interface sbi_clk_if;
  logic       run;
  logic [2:0] rate;
  logic       tick;
  modport gen  (input run, input rate, output tick);
  modport user (output run, output rate, input tick);
endinterface

/* File: core/pin_sync.sv */
// two-stage synchroniser for the four bus pin inputs
`timescale 1ns/10ps
module pin_sync (
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  input  wire logic [3:0] pins_in,
  output logic      [3:0] pins_out
);
  sbi_pkg::sync_state_t q;
  sbi_pkg::sync_state_t d;

  always_comb begin
    d      = q;
    d.meta = pins_in;
    d.sync = q.meta;
  end

  // idle bus lines read high, so reset to ones
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign pins_out = q.sync;
endmodule

/* File: core/scl_divider.sv */
// serial clock divider producing one tick per half bit period
`timescale 1ns/10ps
`include "sbi_regs.svh"
module scl_divider (
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  sbi_clk_if.gen    clk_bus
);
  sbi_pkg::div_state_t q;
  sbi_pkg::div_state_t d;

  always_comb begin
    logic [2:0]  rate_c;
    logic [10:0] half;
    rate_c = (clk_bus.rate > `SCK_MAX) ? `SCK_MAX : clk_bus.rate;
    half   = (`SCL_HALF_BASE << rate_c) + `SCL_HALF_EXTRA;
    d      = q;
    d.tick = 1'b0;
    if (!clk_bus.run) begin
      d.cnt = 11'h000;
    end else if (q.cnt >= half - 11'h001) begin
      d.cnt  = 11'h000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 11'h001;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign clk_bus.tick = q.tick;
endmodule

/* File: core/serial_bus_i2c_interface.sv */
// two-wire bus controller/target and 8-bit synchronous serial port
`timescale 1ns/10ps
`include "sbi_regs.svh"

// Functional notes
// - one channel routed to pair A or B
// - mode field: port, serial port, two-wire
// - code 01 then 10 starts soft reset
// - soft reset four machine cycles, keeps mode
// - bit count 1..7, zero means eight
// - acknowledge mode adds one clock, two-wire mode only
// - controller: release or drive acknowledge slot
// - target acknowledges own address, general call
// - matched target acknowledges per direction
// - start and stop requested through control B
// - status B shows role, direction, bus
// - pending reads zero while service requested
// - match, general call, last bit flags
// - start condition clears bit count
// - recognition off treats all as data
module serial_bus_i2c_interface (
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       clock_line_ch_a_in,
  output logic            clock_line_ch_a_out,
  output logic            clock_line_ch_a_oe_out,
  input  wire logic       data_line_ch_a_in,
  output logic            data_line_ch_a_out,
  output logic            data_line_ch_a_oe_out,
  input  wire logic       clock_line_ch_b_in,
  output logic            clock_line_ch_b_out,
  output logic            clock_line_ch_b_oe_out,
  input  wire logic       data_line_ch_b_in,
  output logic            data_line_ch_b_out,
  output logic            data_line_ch_b_oe_out
);

  // ----------------------------------------------------------------
  // state and sub-blocks
  // ----------------------------------------------------------------
  localparam sbi_pkg::core_state_t RST_STATE = '{
    st:       sbi_pkg::ST_IDLE,
    pending:  `RST_PIN,
    clk_run:  `RST_CLK_RUN,
    scl_p:    1'h1,
    sda_p:    1'h1,
    default:  '0
  };

  sbi_pkg::core_state_t q;
  sbi_pkg::core_state_t d;
  logic [3:0]           sync_w;

  sbi_clk_if clk_if ();

  pin_sync u_sync (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .pins_in   ({data_line_ch_b_in, data_line_ch_a_in,
                 clock_line_ch_b_in, clock_line_ch_a_in}),
    .pins_out  (sync_w)
  );

  scl_divider u_div (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .clk_bus   (clk_if.gen)
  );

  assign clk_if.run  = q.clk_run;
  assign clk_if.rate = q.sck;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic       scl_s;
    logic       sda_s;
    logic       i2c;
    logic       sio;
    logic       ctl;
    logic       rise;
    logic       fall;
    logic       start_det;
    logic       stop_det;
    logic       bitval;
    logic       leave;
    logic       tgt_first;
    logic       dwr;
    logic [3:0] nbits;
    logic [3:0] tot;
    logic [3:0] c;
    logic [7:0] nsh;
    logic [7:0] rd;
    scl_s     = q.channel_select ? sync_w[1] : sync_w[0];
    sda_s     = q.channel_select ? sync_w[3] : sync_w[2];
    // mode decode, code 11 acts as port
    i2c       = (q.operating_mode_sel == `MODE_I2C);
    sio       = (q.operating_mode_sel == `MODE_SIO);
    ctl       = q.controller_role | sio;
    // zero code stands for eight bits
    nbits     = (q.bit_count == `BC_FULL) ? `BITS_FULL : {1'h0, q.bit_count};
    // one more clock in acknowledge mode, none in serial port mode
    tot       = nbits + {3'h0, q.ack_mode & ~sio};
    rise      = scl_s & ~q.scl_p;
    fall      = ~scl_s & q.scl_p;
    start_det = i2c & scl_s & q.scl_p & q.sda_p & ~sda_s;
    stop_det  = i2c & scl_s & q.scl_p & ~q.sda_p & sda_s;
    // a controller samples on its own tick, a target at the rising edge
    bitval    = ctl ? sda_s : q.smp;
    leave     = ctl ? (clk_if.tick & scl_s) : fall;
    // recognition off: first byte is plain data
    tgt_first = q.first & ~ctl & ~q.addr_recognition_off;
    dwr       = wr_in & (addr_in == `OFS_DATA);
    c         = q.cnt + 4'h1;
    nsh       = {q.shreg[6:0], bitval};
    rd        = 8'h00;
    d         = q;
    d.scl_p   = scl_s;
    d.sda_p   = sda_s;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (wr_in) begin
      case (addr_in)
        `OFS_CTRL_A: begin
          d.bit_count = wdata_in[`CRA_BC];
          d.ack_mode  = wdata_in[`CRA_ACK];
          d.sck       = wdata_in[`CRA_SCK];
        end
        `OFS_DATA: begin
          d.shreg   = wdata_in;
          d.pending = 1'h1;
        end
        `OFS_TADDR: begin
          // address in upper bits, flag in bit 0
          d.own_target_addr      = wdata_in[`TA_ADDR];
          d.addr_recognition_off = wdata_in[`TA_ALS];
        end
        `OFS_CTRL_B: begin
          d.controller_role    = wdata_in[`CRB_MST];
          d.transmit_direction = wdata_in[`CRB_TRX];
          d.operating_mode_sel = wdata_in[`CRB_MODE];
          d.arbitration_lost   = 1'h0;
          // pending can be set by software but never cleared
          if (wdata_in[`CRB_PIN]) begin
            d.pending = 1'h1;
          end
          if (wdata_in[`CRB_MST] && wdata_in[`CRB_TRX] && wdata_in[`CRB_PIN]) begin
            if (wdata_in[`CRB_BB] && !q.bus_busy && i2c && q.st == sbi_pkg::ST_IDLE) begin
              d.st = sbi_pkg::ST_START_A;
            end else if (!wdata_in[`CRB_BB] && q.controller_role) begin
              d.stop_req = 1'h1;
            end
          end
          // two-step code arms the soft reset
          if (q.soft_reset_code == `SOFT_RESET_CODE_FIRST && wdata_in[`CRB_SOFT_RESET_CODE] == `SOFT_RESET_CODE_SECOND) begin
            d.srst_cnt = `SRST_CLKS;
          end
          d.soft_reset_code = wdata_in[`CRB_SOFT_RESET_CODE];
        end
        `OFS_PORT_SW: begin
          d.channel_select = wdata_in[`PSW_CHS];
        end
        `OFS_CLK_SRC: begin
          d.clk_run = wdata_in[`CLK_SRC_RUN];
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    if (rd_in) begin
      case (addr_in)
        `OFS_CTRL_A: begin
          rd[`CRA_ACK] = q.ack_mode;
          // monitor low while soft reset runs
          rd[`SRA_MON] = (q.srst_cnt == 5'h00);
        end
        `OFS_DATA: begin
          rd        = q.shreg;
          d.pending = 1'h1;
        end
        `OFS_CTRL_B: begin
          rd = {q.controller_role, q.transmit_direction, q.bus_busy, q.pending,
                q.arbitration_lost, q.address_match_flag, q.general_call_flag,
                q.last_received_bit};
        end
        `OFS_PORT_SW: begin
          rd[`PSW_CHS] = q.channel_select;
        end
        `OFS_CLK_SRC: begin
          rd[`CLK_SRC_RUN] = q.clk_run;
        end
        default: begin
          rd = 8'h00;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // bit engine
    // ----------------------------------------------------------------
    unique case (q.st)
      sbi_pkg::ST_IDLE: begin
        d.scl_drv = 1'h0;
        d.sda_drv = 1'h0;
        if (sio && dwr) begin
          d.st      = sbi_pkg::ST_BIT_LOW;
          d.cnt     = 4'h0;
          d.scl_drv = 1'h1;
          d.sda_drv = q.transmit_direction & ~wdata_in[7];
        end
      end
      sbi_pkg::ST_START_A: begin
        d.scl_drv = 1'h0;
        d.sda_drv = 1'h0;
        if (clk_if.tick && scl_s && sda_s) begin
          d.st      = sbi_pkg::ST_START_B;
          d.sda_drv = 1'h1;
        end
      end
      sbi_pkg::ST_START_B: begin
        if (clk_if.tick) begin
          d.st      = sbi_pkg::ST_BIT_LOW;
          d.scl_drv = 1'h1;
          d.sda_drv = ~q.shreg[7];
        end
      end
      sbi_pkg::ST_BIT_LOW: begin
        if (ctl) begin
          if (clk_if.tick) begin
            d.st      = sbi_pkg::ST_BIT_HIGH;
            d.scl_drv = 1'h0;
          end
        end else if (rise) begin
          d.st  = sbi_pkg::ST_BIT_HIGH;
          d.smp = sda_s;
        end
      end
      sbi_pkg::ST_BIT_HIGH: begin
        if (leave) begin
          if (q.cnt < nbits) begin
            d.shreg             = nsh;
            d.last_received_bit = bitval;
            // compare own address and general call
            if (tgt_first && c == nbits) begin
              d.general_call_flag  = (nsh == `GENERAL_CALL);
              d.address_match_flag = (nsh[7:1] == q.own_target_addr) ||
                                     (nsh == `GENERAL_CALL);
              if (d.address_match_flag) begin
                d.transmit_direction = nsh[0];
              end
            end
          end else begin
            // an acknowledge this side drives itself is not a received bit
            if (!q.sda_drv) begin
              d.last_received_bit = bitval;
            end
            // acknowledged read address turns the controller's direction round
            if (ctl && i2c && q.first && q.transmit_direction && !bitval) begin
              d.transmit_direction = ~q.shreg[0];
            end
          end
          if (c == tot) begin
            d.cnt     = 4'h0;
            d.first   = 1'h0;
            d.sda_drv = 1'h0;
            if (tgt_first && !q.address_match_flag) begin
              d.st      = sbi_pkg::ST_IDLE;
              d.scl_drv = 1'h0;
            end else begin
              d.st      = sbi_pkg::ST_WAIT;
              d.pending = 1'h0;
              d.scl_drv = 1'h1;
            end
          end else begin
            d.cnt     = c;
            d.st      = sbi_pkg::ST_BIT_LOW;
            d.scl_drv = ctl;
            if (c < nbits) begin
              d.sda_drv = ~tgt_first & q.transmit_direction & ~d.shreg[7];
            end else if (tgt_first) begin
              d.sda_drv = d.address_match_flag;
            end else begin
              d.sda_drv = ~q.transmit_direction;
            end
          end
          // a released one read back as zero means another controller won
          if (ctl && i2c && q.cnt < nbits && q.transmit_direction && !q.sda_drv && !bitval) begin
            d.arbitration_lost   = 1'h1;
            d.controller_role    = 1'h0;
            d.transmit_direction = 1'h0;
            d.st                 = sbi_pkg::ST_IDLE;
            d.scl_drv            = 1'h0;
            d.sda_drv            = 1'h0;
          end
        end
      end
      sbi_pkg::ST_WAIT: begin
        d.scl_drv = 1'h1;
        if (d.pending) begin
          if (d.stop_req) begin
            d.st      = sbi_pkg::ST_STOP_A;
            d.sda_drv = 1'h1;
          end else begin
            d.st      = sbi_pkg::ST_BIT_LOW;
            d.scl_drv = ctl;
            d.sda_drv = q.transmit_direction & ~d.shreg[7];
          end
        end
      end
      sbi_pkg::ST_STOP_A: begin
        d.sda_drv = 1'h1;
        d.scl_drv = 1'h1;
        if (clk_if.tick) begin
          d.st      = sbi_pkg::ST_STOP_B;
          d.scl_drv = 1'h0;
        end
      end
      sbi_pkg::ST_STOP_B: begin
        if (clk_if.tick && scl_s) begin
          d.st       = sbi_pkg::ST_IDLE;
          d.sda_drv  = 1'h0;
          d.stop_req = 1'h0;
        end
      end
    endcase

    // ----------------------------------------------------------------
    // bus conditions seen on the lines
    // ----------------------------------------------------------------
    if (start_det) begin
      d.bus_busy           = 1'h1;
      d.bit_count          = `BC_FULL;
      d.address_match_flag = 1'h0;
      d.general_call_flag  = 1'h0;
      d.cnt                = 4'h0;
      d.first              = 1'h1;
      if (!q.controller_role) begin
        d.st      = sbi_pkg::ST_BIT_LOW;
        d.scl_drv = 1'h0;
        d.sda_drv = 1'h0;
      end
    end
    if (stop_det) begin
      d.bus_busy           = 1'h0;
      d.controller_role    = 1'h0;
      d.transmit_direction = 1'h0;
      d.stop_req           = 1'h0;
      d.st                 = sbi_pkg::ST_IDLE;
      d.scl_drv            = 1'h0;
      d.sda_drv            = 1'h0;
    end
    if (!i2c && !sio) begin
      d.st      = sbi_pkg::ST_IDLE;
      d.scl_drv = 1'h0;
      d.sda_drv = 1'h0;
    end

    // ----------------------------------------------------------------
    // soft reset and pin drive
    // ----------------------------------------------------------------
    // hold reset values, keep mode and channel
    if (q.srst_cnt != 5'h00) begin
      d                    = RST_STATE;
      d.operating_mode_sel = q.operating_mode_sel;
      d.channel_select     = q.channel_select;
      d.srst_cnt           = q.srst_cnt - 5'h01;
      d.scl_p              = scl_s;
      d.sda_p              = sda_s;
    end
    d.rdata = rd;
    // enables go only to the selected pair
    d.oe    = (i2c || sio) ? {d.sda_drv & d.channel_select, d.sda_drv & ~d.channel_select,
                              d.scl_drv & d.channel_select, d.scl_drv & ~d.channel_select}
                           : 4'h0;
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open-drain: the level driven is always low, only the enable moves
  assign rdata_out              = q.rdata;
  assign clock_line_ch_a_out    = 1'h0;
  assign clock_line_ch_b_out    = 1'h0;
  assign data_line_ch_a_out     = 1'h0;
  assign data_line_ch_b_out     = 1'h0;
  assign clock_line_ch_a_oe_out = q.oe[0];
  assign clock_line_ch_b_oe_out = q.oe[1];
  assign data_line_ch_a_oe_out  = q.oe[2];
  assign data_line_ch_b_oe_out  = q.oe[3];
endmodule

/* File: dv/sbi_asserts.sv */
// port checker for the serial bus block
`timescale 1ns/10ps
module sbi_asserts (
  input wire logic       mclk_in,
  input wire logic       arst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       clock_line_ch_a_oe_out,
  input wire logic       data_line_ch_a_oe_out,
  input wire logic       clock_line_ch_b_in,
  input wire logic       clock_line_ch_b_out,
  input wire logic       clock_line_ch_b_oe_out,
  input wire logic       data_line_ch_b_out,
  input wire logic       data_line_ch_b_oe_out
);
  logic [1:0] mode_reg;
  logic       chs_reg;
  logic [3:0] oe;
  assign oe = {clock_line_ch_a_oe_out, data_line_ch_a_oe_out,
               clock_line_ch_b_oe_out, data_line_ch_b_oe_out};
  // mode and channel survive a soft reset, so only the async reset clears them
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_reg <= 2'h0;
      chs_reg  <= 1'h0;
    end else if (wr_in && addr_in == 8'h23) begin
      mode_reg <= wdata_in[3:2];
    end else if (wr_in && addr_in == 8'h27) begin
      chs_reg <= wdata_in[6];
    end
  end
  // cycles from a start-like data pull until the clock follows; slowest rate needs ~1030
  logic [10:0] start_wait;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_wait <= 11'h000;
    end else if (clock_line_ch_b_oe_out || !data_line_ch_b_oe_out) begin
      start_wait <= 11'h000;
    end else if (start_wait != 11'h000 ||
                 ($rose(data_line_ch_b_oe_out) && clock_line_ch_b_in)) begin
      start_wait <= start_wait + 11'h001;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  sequence srst_pair;
    wr_in && addr_in == 8'h23 && wdata_in[1:0] == 2'h1 ##1
    wr_in && addr_in == 8'h23 && wdata_in[1:0] == 2'h2;
  endsequence
  a_pins_low: assert property ({clock_line_ch_b_out, data_line_ch_b_out} == 2'h0)
    else $error("line output level not low");
  a_port_quiet: assert property (mode_reg == 2'h0 [*4] |-> oe == 4'h0)
    else $error("pins driven in port mode");
  a_chan_a_quiet: assert property (chs_reg [*4] |-> oe[3:2] == 2'h0)
    else $error("pair A driven with pair B selected");
  a_chan_b_quiet: assert property (!chs_reg [*4] |-> oe[1:0] == 2'h0)
    else $error("pair B driven with pair A selected");
  a_addr_reads_zero: assert property (rd_in && addr_in == 8'h22 |=> rdata_out == 8'h00)
    else $error("address register readable");
  a_srst_monitor: assert property (srst_pair ##1 (rd_in && addr_in == 8'h20) |=> !rdata_out[0])
    else $error("reset monitor high during soft reset");
  a_srst_status: assert property (srst_pair ##1 rd_in ##1 (rd_in && addr_in == 8'h23)
    |=> rdata_out == 8'h10)
    else $error("status not initial during soft reset");
  a_start_order: assert property (start_wait <= 11'h420)
    else $error("clock not pulled after start");
endmodule
bind serial_bus_i2c_interface sbi_asserts i_chk (.mclk_in, .arst_n_in, .addr_in, .wdata_in,
  .wr_in, .rd_in, .rdata_out, .clock_line_ch_a_oe_out, .data_line_ch_a_oe_out,
  .clock_line_ch_b_in, .clock_line_ch_b_out, .clock_line_ch_b_oe_out, .data_line_ch_b_out,
  .data_line_ch_b_oe_out);

/* File: dv/i2c_ctl_model.sv */
// behavioural two-wire controller addressing the block on pair B
`timescale 1ns/10ps
module i2c_ctl_model (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_oe_out,
  output logic      sda_oe_out
);
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  // clock stands still between frames; lines only ever pulled low
  // open drain
  task automatic frame(input logic [7:0] b, output logic ack);
    integer i;
    // step off the clock edge so the pin flops never race the model
    #10;
    sda_oe_out = 1'b1;
    #160;
    scl_oe_out = 1'b1;
    for (i = 7; i >= -1; i--) begin
      sda_oe_out = (i >= 0) ? !b[i] : 1'b0;
      #160;
      scl_oe_out = 1'b0;
      #80;
      ack = sda_in;
      #80;
      scl_oe_out = 1'b1;
    end
    sda_oe_out = 1'b0;
    #80;
    scl_oe_out = 1'b0;
    #320;
  endtask
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the serial bus block
`timescale 1ns/10ps
module tb_top;
  logic        mclk_in;
  logic        arst_n_in;
  logic [7:0]  addr_in;
  logic [7:0]  wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [7:0]  rdata_out;
  logic        clock_line_ch_a_oe_out;
  logic        data_line_ch_a_oe_out;
  logic        clock_line_ch_b_oe_out;
  logic        data_line_ch_b_oe_out;
  logic        scl_oe;
  logic        sda_oe;
  logic        rd_q;
  logic        ack;
  logic        ack_oe;
  logic        hit;
  logic [6:0]  own;
  logic [7:0]  b;
  logic [15:0] x;
  logic [15:0] xq[$];
  integer      miscompares = 0;
  integer      checks_done = 0;
  integer      nrise = 0;
  integer      seed = 32'h1798b449;
  integer      i;
  integer      k;
  wire         scl_b = !(clock_line_ch_b_oe_out || scl_oe);
  wire         sda_b = !(data_line_ch_b_oe_out || sda_oe);
  serial_bus_i2c_interface i_dut (.mclk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .clock_line_ch_a_in(1'b1), .clock_line_ch_a_out(), .clock_line_ch_a_oe_out,
    .data_line_ch_a_in(1'b1), .data_line_ch_a_out(), .data_line_ch_a_oe_out,
    .clock_line_ch_b_in(scl_b), .clock_line_ch_b_out(), .clock_line_ch_b_oe_out,
    .data_line_ch_b_in(sda_b), .data_line_ch_b_out(), .data_line_ch_b_oe_out);
  i2c_ctl_model i_ctl (.scl_in(scl_b), .sda_in(sda_b), .scl_oe_out(scl_oe),
    .sda_oe_out(sda_oe));
  always #20 mclk_in = !mclk_in;
  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
  endtask
  task automatic idle();
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    xq.push_back({m, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge mclk_in) rd_q <= rd_in;
  always @(negedge mclk_in) begin
    if (rd_q) begin
      x = xq.pop_front();
      chk("rdata", rdata_out & x[15:8], x[7:0]);
    end
  end
  always @(posedge scl_b) begin
    if (nrise - k == 8) ack_oe = data_line_ch_b_oe_out;
    nrise = nrise + 1;
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {wr_in, rd_in, addr_in, wdata_in} = 18'h0;
    mclk_in = 1'b0;
    arst_n_in = 1'b0;
    repeat (20) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rdx(8'h23, 8'hFF, 8'h10);
    rdx(8'h20, 8'hFF, 8'h01);
    rdx(8'h22, 8'hFF, 8'h00);
    rdx(8'h25, 8'hFF, 8'h00);
    bus(1'b1, 8'h27, 8'h40);
    bus(1'b1, 8'h23, 8'h18);
    own = 7'($random(seed)) | 7'h01;
    for (k = 0; k < 3; k++) begin
      // rate code 3 stays within standard mode
      bus(1'b1, 8'h20, 8'h13);
      bus(1'b1, 8'h22, {own, 1'b0});
      idle();
      b = (k == 0) ? {own, 1'($random(seed))} : (k == 1) ? 8'h00 : {own ^ 7'h40, 1'b0};
      hit = (b[7:1] == own) || (b == 8'h00);
      i_ctl.frame(b, ack);
      @(posedge mclk_in);
      chk("ack", {7'h00, ack}, {7'h00, !hit});
      rdx(8'h23, hit ? 8'hFF : 8'hFC, hit ? {1'b0, b[0], 4'h9, b == 8'h00, b[0]} : 8'h30);
      // soft reset keeps mode and channel, so the next frame still lands
      // control B is only ever written whole
      bus(1'b1, 8'h23, 8'h09);
      bus(1'b1, 8'h23, 8'h0A);
      rdx(8'h20, 8'h01, 8'h00);
      rdx(8'h23, 8'hFF, 8'h10);
      idle();
      repeat (24) @(posedge mclk_in);
      rdx(8'h20, 8'hFF, 8'h01);
    end
    // rate code 3 stays within standard mode
    bus(1'b1, 8'h20, 8'h73);
    bus(1'b1, 8'h21, 8'hA4);
    k = nrise;
    // source stopped: the start request waits for ticks
    bus(1'b1, 8'h24, 8'h00);
    bus(1'b1, 8'h23, 8'hF8);
    idle();
    repeat (300) @(posedge mclk_in);
    chk("start_held", {7'h00, data_line_ch_b_oe_out}, 8'h00);
    bus(1'b1, 8'h24, 8'h01);
    idle();
    for (i = 0; i < 4000 && !(nrise - k == 9 && !scl_b); i++) @(posedge mclk_in);
    // a hung transfer counts against the run and falls through to the report
    if (i == 4000) begin
      miscompares++;
    end
    repeat (8) @(posedge mclk_in);
    rdx(8'h23, 8'hFF, 8'hE1);
    idle();
    chk("clocks", 8'(nrise - k), 8'h09);
    chk("ack_oe", {7'h00, ack_oe}, 8'h00);
    repeat (2) @(posedge mclk_in);
    tally_and_finish();
  end
endmodule
